// ### hw/adcpc_defs.svh
// adcpc_defs.svh: register offsets, field positions and reset values
// assumes inclusion by bare name from the package and the register bank
`ifndef ADCPC_DEFS_SVH
`define ADCPC_DEFS_SVH

`define ADCPC_ADDR_W            13
`define ADCPC_INSTR_BITS        16
`define ADCPC_DATA_BITS         8
`define ADCPC_ADDR_CHAN_SEL     13'h0005
`define ADCPC_ADDR_PATT2_LOW    13'h001B
`define ADCPC_ADDR_PATT2_HIGH   13'h001C
`define ADCPC_ADDR_STREAM_SETUP 13'h0021
`define ADCPC_ADDR_CHAN_CTRL    13'h0022
`define ADCPC_BIT_LSB_FIRST     7
`define ADCPC_BIT_LOW_RATE      3
`define ADCPC_BIT_CHAN_OUT_RST  1
`define ADCPC_BIT_CHAN_PWR_DN   0
`define ADCPC_BIT_READ          15
`define ADCPC_RST_PATT2         8'h00
`define ADCPC_RST_STREAM_SETUP  8'h00
`define ADCPC_RST_LSB_FIRST     1'b0
`define ADCPC_RST_LOW_RATE      1'b0
`define ADCPC_RST_CHAN_CTRL     1'b0
`define ADCPC_RST_CHAN_SEL      4'hF

`endif

// ### hw/adcpc_pkg.sv
// adcpc_pkg.sv: types shared by the register bank
// assumes adcpc_defs.svh on the include path
`include "adcpc_defs.svh"

package adcpc_pkg;
   typedef enum logic [1:0] {
      ADCPC_IDLE  = 2'h0,
      ADCPC_INSTR = 2'h1,
      ADCPC_DATA  = 2'h3,
      ADCPC_HOLD  = 2'h2
   } adcpc_state_t;
   typedef logic [`ADCPC_ADDR_W-1:0] adcpc_addr_t;
   typedef logic [7:0]               adcpc_byte_t;
endpackage

// ### hw/adcpc_regs.sv
// adcpc_regs.sv: serial control port slave with the pattern and channel control registers
// assumes sclk, sdio and csb from pins; frame strobe and pattern 1 from logic on i_sys_clk
//
// Function
// - register 1B holds pattern two bits 7..0, reset zero.
// - register 1C holds pattern two bits 15..8, reset zero.
// - register 21 bit 7 selects lsb-first serial words for all channels.
// - register 21 bit 3 selects low encode rate mode, off at reset.
// - register 22 bit 0 powers down only the addressed channels.
// - register 22 bit 1 holds addressed channels' output path in reset.
`timescale 1ns/1ps
`default_nettype none
`include "adcpc_defs.svh"

module adcpc_regs #(
   parameter int N_CHAN = 4
) (
   input  wire logic                i_sys_clk,
   input  wire logic                i_rst,
   input  wire logic                i_clk_en,
   input  wire logic                i_spi_sclk,
   input  wire logic                i_spi_csb_n,
   input  wire logic                i_spi_sdio,
   output logic                     o_spi_sdio,
   output logic                     o_spi_sdio_oe,
   input  wire logic                i_alt_pattern_en,
   input  wire logic                i_frame_strobe,
   input  wire logic [15:0]         i_patt1,
   output logic      [15:0]         o_pattern_word,
   output logic      [15:0]         o_patt2,
   output logic                     o_lsb_first,
   output logic                     o_low_rate_mode,
   output logic      [N_CHAN-1:0]   o_chan_power_down,
   output logic      [N_CHAN-1:0]   o_chan_output_reset
);
   import adcpc_pkg::*;

   // channel select field is four bits wide
   if (N_CHAN < 1 || N_CHAN > 4) begin : g_bad_chan
      $error("N_CHAN must be 1 to 4");
   end

   // pin synchronisers and edge history
   logic [2:0]             sclk_s;
   logic [1:0]             csb_s;
   logic [1:0]             sdi_s;
   // port state
   adcpc_state_t           state;
   logic [4:0]             cnt;
   logic [15:0]            instr;
   adcpc_byte_t            shift;
   adcpc_byte_t            rd_byte;
   // registers
   adcpc_byte_t            patt2_low;
   adcpc_byte_t            patt2_high;
   logic                   lsb_first;
   logic                   low_rate;
   logic [3:0]             chan_sel;
   logic [N_CHAN-1:0]      pwr_dn;
   logic [N_CHAN-1:0]      out_rst;
   logic                   alt_phase;
   logic [15:0]            pattern_word;

   adcpc_state_t           next_state;
   logic [4:0]             next_cnt;
   logic [15:0]            next_instr;
   adcpc_byte_t            next_shift;
   adcpc_byte_t            next_rd_byte;
   logic                   next_sdo;
   logic                   next_sdo_oe;
   adcpc_byte_t            next_patt2_low;
   adcpc_byte_t            next_patt2_high;
   logic                   next_lsb_first;
   logic                   next_low_rate;
   logic [3:0]             next_chan_sel;
   logic [N_CHAN-1:0]      next_pwr_dn;
   logic [N_CHAN-1:0]      next_out_rst;
   logic                   next_alt_phase;
   logic [15:0]            next_pattern_word;

   logic                   sclk_rise;
   logic                   sclk_fall;
   logic                   sdi;
   logic                   csb_high;
   logic [15:0]            instr_full;
   adcpc_byte_t            wr_byte;

   // byte seen at a register address; first selected channel for the local one
   function automatic adcpc_byte_t reg_read(input adcpc_addr_t addr);
      adcpc_byte_t v;
      v = 8'h00;
      unique case (addr)
         `ADCPC_ADDR_CHAN_SEL: v = {4'h0, chan_sel};
         `ADCPC_ADDR_PATT2_LOW: v = patt2_low;
         `ADCPC_ADDR_PATT2_HIGH: v = patt2_high;
         `ADCPC_ADDR_STREAM_SETUP: begin
            v[`ADCPC_BIT_LSB_FIRST] = lsb_first;
            v[`ADCPC_BIT_LOW_RATE]  = low_rate;
         end
         `ADCPC_ADDR_CHAN_CTRL: begin
            for (int i = N_CHAN - 1; i >= 0; i--) begin
               if (chan_sel[i]) begin
                  v[`ADCPC_BIT_CHAN_OUT_RST] = out_rst[i];
                  v[`ADCPC_BIT_CHAN_PWR_DN]  = pwr_dn[i];
               end
            end
         end
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   always_comb begin
      sclk_rise  = sclk_s[1] & ~sclk_s[2];
      sclk_fall  = ~sclk_s[1] & sclk_s[2];
      sdi        = sdi_s[1];
      csb_high   = csb_s[1];
      instr_full = {instr[14:0], sdi};
      wr_byte    = {shift[6:0], sdi};

      next_state        = state;
      next_cnt          = cnt;
      next_instr        = instr;
      next_shift        = shift;
      next_rd_byte      = rd_byte;
      next_sdo          = o_spi_sdio;
      next_sdo_oe       = o_spi_sdio_oe;
      next_patt2_low    = patt2_low;
      next_patt2_high   = patt2_high;
      next_lsb_first    = lsb_first;
      next_low_rate     = low_rate;
      next_chan_sel     = chan_sel;
      next_pwr_dn       = pwr_dn;
      next_out_rst      = out_rst;
      next_alt_phase    = alt_phase;
      next_pattern_word = pattern_word;

      if (csb_high) begin
         next_state  = ADCPC_IDLE;
         next_cnt    = 5'h00;
         next_sdo_oe = 1'b0;
      end else begin
         unique case (state)
            ADCPC_IDLE: begin
               next_state = ADCPC_INSTR;
               next_cnt   = 5'h00;
            end
            ADCPC_INSTR: begin
               if (sclk_rise) begin
                  next_instr = instr_full;
                  if (cnt == 5'(`ADCPC_INSTR_BITS - 1)) begin
                     next_state   = ADCPC_DATA;
                     next_cnt     = 5'h00;
                     next_rd_byte = reg_read(instr_full[`ADCPC_ADDR_W-1:0]);
                  end else begin
                     next_cnt = cnt + 5'h01;
                  end
               end
            end
            ADCPC_DATA: begin
               if (instr[`ADCPC_BIT_READ]) begin
                  if (sclk_fall) begin
                     next_sdo_oe  = 1'b1;
                     next_sdo     = rd_byte[7];
                     next_rd_byte = {rd_byte[6:0], 1'b0};
                  end
               end
               if (sclk_rise) begin
                  next_shift = wr_byte;
                  if (cnt == 5'(`ADCPC_DATA_BITS - 1)) begin
                     next_state = ADCPC_HOLD;
                     if (!instr[`ADCPC_BIT_READ]) begin
                        unique case (instr[`ADCPC_ADDR_W-1:0])
                           `ADCPC_ADDR_CHAN_SEL: next_chan_sel = wr_byte[3:0];
                           `ADCPC_ADDR_PATT2_LOW: next_patt2_low = wr_byte;
                           `ADCPC_ADDR_PATT2_HIGH: next_patt2_high = wr_byte;
                           `ADCPC_ADDR_STREAM_SETUP: begin
                              next_lsb_first = wr_byte[`ADCPC_BIT_LSB_FIRST];
                              next_low_rate  = wr_byte[`ADCPC_BIT_LOW_RATE];
                           end
                           `ADCPC_ADDR_CHAN_CTRL: begin
                              for (int i = 0; i < N_CHAN; i++) begin
                                 if (chan_sel[i]) begin
                                    next_pwr_dn[i]  = wr_byte[`ADCPC_BIT_CHAN_PWR_DN];
                                    next_out_rst[i] = wr_byte[`ADCPC_BIT_CHAN_OUT_RST];
                                 end
                              end
                           end
                           default: next_shift = wr_byte;
                        endcase
                     end
                  end else begin
                     next_cnt = cnt + 5'h01;
                  end
               end
            end
            ADCPC_HOLD: begin
               if (sclk_fall) begin
                  next_sdo_oe = 1'b0;
               end
            end
         endcase
      end

      // alternate the two user patterns per frame
      if (!i_alt_pattern_en) begin
         next_alt_phase    = 1'b0;
         next_pattern_word = i_patt1;
      end else if (i_frame_strobe) begin
         next_alt_phase    = ~alt_phase;
         next_pattern_word = alt_phase ? {patt2_high, patt2_low} : i_patt1;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         sclk_s              <= 3'h0;
         csb_s               <= 2'h3;
         sdi_s               <= 2'h0;
         state               <= ADCPC_IDLE;
         cnt                 <= 5'h00;
         instr               <= 16'h0000;
         shift               <= 8'h00;
         rd_byte             <= 8'h00;
         o_spi_sdio          <= 1'b0;
         o_spi_sdio_oe       <= 1'b0;
         patt2_low           <= `ADCPC_RST_PATT2;
         patt2_high          <= `ADCPC_RST_PATT2;
         lsb_first           <= `ADCPC_RST_LSB_FIRST;
         low_rate            <= `ADCPC_RST_LOW_RATE;
         chan_sel            <= `ADCPC_RST_CHAN_SEL;
         pwr_dn              <= {N_CHAN{`ADCPC_RST_CHAN_CTRL}};
         out_rst             <= {N_CHAN{`ADCPC_RST_CHAN_CTRL}};
         alt_phase           <= 1'b0;
         pattern_word        <= 16'h0000;
         o_pattern_word      <= 16'h0000;
         o_patt2             <= 16'h0000;
         o_lsb_first         <= 1'b0;
         o_low_rate_mode     <= 1'b0;
         o_chan_power_down   <= '0;
         o_chan_output_reset <= '0;
      end else if (i_clk_en) begin
         sclk_s              <= {sclk_s[1:0], i_spi_sclk};
         csb_s               <= {csb_s[0], i_spi_csb_n};
         sdi_s               <= {sdi_s[0], i_spi_sdio};
         state               <= next_state;
         cnt                 <= next_cnt;
         instr               <= next_instr;
         shift               <= next_shift;
         rd_byte             <= next_rd_byte;
         o_spi_sdio          <= next_sdo;
         o_spi_sdio_oe       <= next_sdo_oe;
         patt2_low           <= next_patt2_low;
         patt2_high          <= next_patt2_high;
         lsb_first           <= next_lsb_first;
         low_rate            <= next_low_rate;
         chan_sel            <= next_chan_sel;
         pwr_dn              <= next_pwr_dn;
         out_rst             <= next_out_rst;
         alt_phase           <= next_alt_phase;
         pattern_word        <= next_pattern_word;
         o_pattern_word      <= next_pattern_word;
         o_patt2             <= {next_patt2_high, next_patt2_low};
         o_lsb_first         <= next_lsb_first;
         o_low_rate_mode     <= next_low_rate;
         o_chan_power_down   <= next_pwr_dn;
         o_chan_output_reset <= next_out_rst;
      end
   end
endmodule

`default_nettype wire

// ### tb/adcpc_regs_sva.sv
// adcpc_regs_sva.sv: port checker for the pattern and channel control registers
// assumes binding onto adcpc_regs; quiet means csb high for 8 clocks
`timescale 1ns/1ps
`default_nettype none
module adcpc_regs_chk #(
   parameter int N_CHAN = 4
) (
   input wire logic              i_sys_clk,
   input wire logic              i_rst,
   input wire logic              i_clk_en,
   input wire logic              i_spi_sclk,
   input wire logic              i_spi_csb_n,
   input wire logic              i_spi_sdio,
   input wire logic              o_spi_sdio,
   input wire logic              o_spi_sdio_oe,
   input wire logic              i_alt_pattern_en,
   input wire logic              i_frame_strobe,
   input wire logic [15:0]       i_patt1,
   input wire logic [15:0]       o_pattern_word,
   input wire logic [15:0]       o_patt2,
   input wire logic              o_lsb_first,
   input wire logic              o_low_rate_mode,
   input wire logic [N_CHAN-1:0] o_chan_power_down,
   input wire logic [N_CHAN-1:0] o_chan_output_reset
);
   logic [3:0] quiet_cnt;
   logic [3:0] next_quiet_cnt;
   logic       quiet;
   logic       exp_phase;
   logic       next_exp_phase;
   // expected pattern phase: second pattern on every other strobe
   always_comb begin
      next_exp_phase = exp_phase;
      if (i_clk_en) begin
         if (!i_alt_pattern_en) begin
            next_exp_phase = 1'b0;
         end else if (i_frame_strobe) begin
            next_exp_phase = ~exp_phase;
         end
      end
   end
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         exp_phase <= 1'b0;
      end else begin
         exp_phase <= next_exp_phase;
      end
   end
   // cycles since csb last went high
   always_comb begin
      next_quiet_cnt = quiet_cnt;
      if (i_spi_csb_n == 1'b0) begin
         next_quiet_cnt = 4'h0;
      end else if (quiet_cnt != 4'hF) begin
         next_quiet_cnt = quiet_cnt + 4'h1;
      end
   end
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         quiet_cnt <= 4'h0;
      end else begin
         quiet_cnt <= next_quiet_cnt;
      end
   end
   assign quiet = (quiet_cnt >= 4'h8);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   property p_patt2_low; quiet |-> $stable(o_patt2[7:0]); endproperty
   a_patt2_low: assert property (p_patt2_low) else $error("low pattern byte moved");
   property p_patt2_high; quiet |-> $stable(o_patt2[15:8]); endproperty
   a_patt2_high: assert property (p_patt2_high) else $error("high pattern byte moved");
   property p_lsb_first; quiet |-> $stable(o_lsb_first); endproperty
   a_lsb_first: assert property (p_lsb_first) else $error("bit order moved");
   property p_low_rate; quiet |-> $stable(o_low_rate_mode); endproperty
   a_low_rate: assert property (p_low_rate) else $error("low rate moved");
   property p_pwr_dn; quiet |-> $stable(o_chan_power_down); endproperty
   a_pwr_dn: assert property (p_pwr_dn) else $error("power down moved");
   property p_out_rst; quiet ##1 quiet |-> $stable(o_chan_output_reset); endproperty
   a_out_rst: assert property (p_out_rst) else $error("output reset moved");
   property p_word_plain; quiet && i_clk_en && !i_alt_pattern_en |=> o_pattern_word == $past(i_patt1); endproperty
   a_word_plain: assert property (p_word_plain) else $error("word not pattern one");
   property p_word_hold; quiet && i_clk_en && i_alt_pattern_en && !i_frame_strobe |=> $stable(o_pattern_word); endproperty
   a_word_hold: assert property (p_word_hold) else $error("word moved without strobe");
   property p_word_alt;
      quiet && i_clk_en && i_alt_pattern_en && i_frame_strobe
         |=> o_pattern_word == ($past(exp_phase) ? $past(o_patt2) : $past(i_patt1));
   endproperty
   a_word_alt: assert property (p_word_alt) else $error("word not a user pattern");
endmodule
bind adcpc_regs adcpc_regs_chk #(.N_CHAN(N_CHAN)) chk_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
   .i_clk_en(i_clk_en), .i_spi_sclk(i_spi_sclk), .i_spi_csb_n(i_spi_csb_n), .i_spi_sdio(i_spi_sdio),
   .o_spi_sdio(o_spi_sdio), .o_spi_sdio_oe(o_spi_sdio_oe), .i_alt_pattern_en(i_alt_pattern_en),
   .i_frame_strobe(i_frame_strobe), .i_patt1(i_patt1), .o_pattern_word(o_pattern_word), .o_patt2(o_patt2),
   .o_lsb_first(o_lsb_first), .o_low_rate_mode(o_low_rate_mode), .o_chan_power_down(o_chan_power_down),
   .o_chan_output_reset(o_chan_output_reset));
`default_nettype wire

// ### tb/adcpc_regs_tb_top.sv
// adcpc_regs_tb_top.sv: self-checking bench for the pattern and channel control registers
// assumes adcpc_regs and its checker compiled first; sdio line pulled up
`timescale 1ns/1ps
`default_nettype none
`include "adcpc_defs.svh"
module adcpc_regs_tb_top;
   import adcpc_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        sclk    = 1'b0;
   logic        csb_n   = 1'b1;
   logic        tb_sdio = 1'b0;
   logic        tb_en   = 1'b1;
   logic        clk_en  = 1'b1;
   logic        alt_en  = 1'b0;
   logic        strobe  = 1'b0;
   logic [15:0] patt1   = 16'h0000;
   logic        sdio_pin, sdio_out, sdio_oe, lsb_first, low_rate;
   logic [15:0] word, patt2;
   logic [3:0]  pwr_dn, out_rst;
   logic [7:0]  rd_byte;
   int          err_count = 0;
   int          checks    = 0;
   int          cyc_count = 0;
   assign sdio_pin = sdio_oe ? sdio_out : (tb_en ? tb_sdio : 1'b1);
   always #50 sys_clk = ~sys_clk;
   adcpc_regs #(.N_CHAN(4)) dut_u (.i_sys_clk(sys_clk), .i_rst(rst), .i_clk_en(clk_en), .i_spi_sclk(sclk),
      .i_spi_csb_n(csb_n), .i_spi_sdio(sdio_pin), .o_spi_sdio(sdio_out), .o_spi_sdio_oe(sdio_oe),
      .i_alt_pattern_en(alt_en), .i_frame_strobe(strobe), .i_patt1(patt1), .o_pattern_word(word),
      .o_patt2(patt2), .o_lsb_first(lsb_first), .o_low_rate_mode(low_rate), .o_chan_power_down(pwr_dn),
      .o_chan_output_reset(out_rst));
   task automatic final_report;
      $display("checks=%0d errors=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #10;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one serial frame: 16 instruction bits then 8 data bits, msb first
   task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wd);
      logic [23:0] frame;
      frame = {rd, 2'h0, addr, wd};
      csb_n = 1'b0;
      cyc(5);
      for (int i = 23; i >= 0; i--) begin
         tb_sdio = frame[i];
         tb_en = !(rd && i < 8);
         cyc(5);
         if (i < 8) rd_byte[i] = sdio_pin;
         sclk = 1'b1;
         cyc(5);
         sclk = 1'b0;
      end
      cyc(5);
      csb_n = 1'b1;
      tb_en = 1'b1;
      cyc(8);
   endtask
   task automatic rd_chk(input logic [12:0] addr, input logic [7:0] exp);
      xfer(1'b1, addr, 8'h00);
      chk({8'h00, rd_byte}, {8'h00, exp});
   endtask
   task automatic step_word(input logic [15:0] exp);
      strobe = 1'b1;
      cyc(1);
      strobe = 1'b0;
      cyc(1);
      chk(word, exp);
   endtask
   always @(posedge sys_clk) begin
      cyc_count++;
      if (cyc_count == 20000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      cyc(20);
      rst = 1'b0;
      cyc(4);
      chk(patt2, 16'h0000);
      chk({14'h0000, lsb_first, low_rate}, 16'h0000);
      chk({pwr_dn, out_rst}, 16'h0000);
      xfer(1'b0, `ADCPC_ADDR_PATT2_LOW, 8'hA5);
      rd_chk(`ADCPC_ADDR_PATT2_LOW, 8'hA5);
      chk(patt2, 16'h00A5);
      xfer(1'b0, `ADCPC_ADDR_PATT2_HIGH, 8'h3C);
      rd_chk(`ADCPC_ADDR_PATT2_HIGH, 8'h3C);
      chk(patt2, 16'h3CA5);
      xfer(1'b0, `ADCPC_ADDR_STREAM_SETUP, 8'h80);
      chk({14'h0000, lsb_first, low_rate}, 16'h0002);
      xfer(1'b0, `ADCPC_ADDR_STREAM_SETUP, 8'h08);
      chk({14'h0000, lsb_first, low_rate}, 16'h0001);
      rd_chk(`ADCPC_ADDR_STREAM_SETUP, 8'h08);
      xfer(1'b0, `ADCPC_ADDR_CHAN_SEL, 8'h02);
      xfer(1'b0, `ADCPC_ADDR_CHAN_CTRL, 8'h01);
      chk({pwr_dn, out_rst}, 16'h0020);
      xfer(1'b0, `ADCPC_ADDR_CHAN_SEL, 8'h04);
      xfer(1'b0, `ADCPC_ADDR_CHAN_CTRL, 8'h02);
      chk({pwr_dn, out_rst}, 16'h0024);
      rd_chk(`ADCPC_ADDR_CHAN_CTRL, 8'h02);
      rd_chk(13'h0030, 8'h00);
      patt1 = 16'h1234;
      cyc(3);
      chk(word, 16'h1234);
      alt_en = 1'b1;
      cyc(2);
      step_word(16'h1234);
      step_word(16'h3CA5);
      step_word(16'h1234);
      // clock enable low: a frame and a new pattern one are ignored
      clk_en = 1'b0;
      patt1 = 16'h5678;
      xfer(1'b0, `ADCPC_ADDR_PATT2_LOW, 8'h11);
      chk(patt2, 16'h3CA5);
      chk(word, 16'h1234);
      clk_en = 1'b1;
      cyc(3);
      chk(word, 16'h1234);
      step_word(16'h3CA5);
      // reset in mid-run returns every register to its default
      rst = 1'b1;
      cyc(2);
      chk(patt2, 16'h0000);
      rst = 1'b0;
      cyc(2);
      chk({14'h0000, lsb_first, low_rate}, 16'h0000);
      chk({pwr_dn, out_rst}, 16'h0000);
      chk(word, 16'h0000);
      rd_chk(`ADCPC_ADDR_CHAN_SEL, 8'h0F);
      xfer(1'b0, `ADCPC_ADDR_CHAN_CTRL, 8'h03);
      chk({pwr_dn, out_rst}, 16'h00FF);
      rd_chk(`ADCPC_ADDR_CHAN_CTRL, 8'h03);
      final_report();
   end
endmodule
`default_nettype wire
